// >>> wls_supervisor.sv
`timescale 1ns/10ps
`default_nettype none

module wls_supervisor (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire wls_pkg::wls_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic watchdog_strobe_input_i,
    input wire logic lamp_gate_input_one_i,
    input wire logic lamp_gate_input_two_i,
    input wire wls_pkg::wls_fault_in_t fault_in_i,
    input wire logic reset_line_in_i,
    output logic reset_line_oe_o,
    output logic low_voltage_lamp_driver_oe_o,
    output logic lamp_driver_one_o,
    output logic lamp_driver_two_o,
    output logic watchdog_ok_flag_o,
    output logic watchdog_fault_bit_o,
    output logic function_inhibit_o
);
    localparam int NSYNC = 10;

    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic strobe_s, strobe_prev_reg, rline_s;
    logic [1:0] gate_s, oc_s, ol_s;
    logic ot_s, uv_s;

    assign pins_raw = {reset_line_in_i, fault_in_i, lamp_gate_input_two_i, lamp_gate_input_one_i,
                       watchdog_strobe_input_i};

    // second stage alone feeds logic
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            strobe_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            strobe_prev_reg <= sync2_reg[0];
        end
    end

    assign strobe_s = sync2_reg[0];
    assign gate_s = sync2_reg[2:1];
    assign oc_s = sync2_reg[4:3];
    assign ol_s = sync2_reg[6:5];
    assign ot_s = sync2_reg[7];
    assign uv_s = sync2_reg[8];
    assign rline_s = sync2_reg[9];

    // register access
    logic [7:0] ctrl_reg;
    logic rd_sum, rd_lamp, rd_wd, wr_ctrl;
    logic watchdog_enable_bit;
    assign rd_sum = reg_req_i.rd && reg_req_i.addr == wls_pkg::ADDR_FAULT_SUMMARY;
    assign rd_lamp = reg_req_i.rd && reg_req_i.addr == wls_pkg::ADDR_LAMP_FAULT;
    assign rd_wd = reg_req_i.rd && reg_req_i.addr == wls_pkg::ADDR_WD_STATUS;
    assign wr_ctrl = reg_req_i.wr && reg_req_i.addr == wls_pkg::ADDR_WD_CONTROL;
    assign watchdog_enable_bit = ctrl_reg[wls_pkg::WC_ENABLE_BIT];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_reg <= wls_pkg::WD_CONTROL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_req_i.wdata;
        end
    end

    // deglitch: index 0/1 overcurrent, 2 overtemperature
    logic [13:0] dg_cnt_reg [3];
    logic [2:0] dg_det;
    logic [2:0] dg_raw;
    assign dg_raw = {ot_s, oc_s};

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < 3; i++) begin
                dg_cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!dg_raw[i]) begin
                    dg_cnt_reg[i] <= '0;
                end else if (!dg_det[i]) begin
                    dg_cnt_reg[i] <= dg_cnt_reg[i] + 14'h0001;
                end
            end
        end
    end

    assign dg_det[0] = dg_cnt_reg[0] >= wls_pkg::OC_BLANK_CYC;
    assign dg_det[1] = dg_cnt_reg[1] >= wls_pkg::OC_BLANK_CYC;
    assign dg_det[2] = dg_cnt_reg[2] >= wls_pkg::OT_DEGLITCH_CYC;

    // lamp drivers and fault flags
    logic [1:0] lamp_on_reg;
    logic [1:0] ge;
    logic [1:0] ol_set;
    logic watchdog_fault_bit_reg, wd_ok_reg;
    logic [7:0] lamp_fault_reg, lamp_fault_set;
    logic [2:0] sum_reg;
    logic erst_set;
    logic lamp_block;

    assign ge = {ctrl_reg[wls_pkg::WC_GE_TWO_BIT], ctrl_reg[wls_pkg::WC_GE_ONE_BIT]};
    // present conditions and the enabled watchdog fault bit; stored fault flags never gate drivers
    assign lamp_block = dg_det[2] || uv_s || (watchdog_enable_bit && watchdog_fault_bit_reg);
    assign ol_set = ol_s & ~lamp_on_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lamp_on_reg <= '0;
        end else begin
            lamp_on_reg <= gate_s & ge & {2{!lamp_block}};
        end
    end

    always_comb begin
        lamp_fault_set = 8'h00;
        lamp_fault_set[wls_pkg::LF_OC_ONE_BIT] = dg_det[0];
        lamp_fault_set[wls_pkg::LF_OC_TWO_BIT] = dg_det[1];
        lamp_fault_set[wls_pkg::LF_OL_ONE_BIT] = ol_set[0];
        lamp_fault_set[wls_pkg::LF_OL_TWO_BIT] = ol_set[1];
        lamp_fault_set[wls_pkg::LF_OT_BIT] = dg_det[2];
    end

    // set wins over the read-clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lamp_fault_reg <= '0;
        end else begin
            lamp_fault_reg <= (lamp_fault_reg & {8{!rd_lamp}}) | lamp_fault_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sum_reg <= '0;
        end else begin
            sum_reg[wls_pkg::SUM_MASTER_BIT] <= (sum_reg[wls_pkg::SUM_MASTER_BIT] && !rd_sum)
                || (|dg_det[1:0]) || (|ol_set);
            sum_reg[wls_pkg::SUM_UNDERVOLT_BIT] <= (sum_reg[wls_pkg::SUM_UNDERVOLT_BIT] && !rd_sum)
                || uv_s;
            sum_reg[wls_pkg::SUM_EXT_RESET_BIT] <= (sum_reg[wls_pkg::SUM_EXT_RESET_BIT] && !rd_sum)
                || erst_set;
        end
    end

    // watchdog
    wls_pkg::wls_wd_state_t wd_state_reg;
    logic [13:0] wd_timer_reg, width_reg, idle_reg;
    logic [2:0] wd_count_reg, count_next;
    logic measuring_reg, rst_drive_reg;
    logic rise, fall, good_pulse, bad_pulse, timeout;
    logic [13:0] lo_lim, hi_lim;
    logic [14:0] idle_lim;

    assign rise = strobe_s && !strobe_prev_reg;
    assign fall = !strobe_s && strobe_prev_reg;
    assign lo_lim = wls_pkg::win_low_cycles(ctrl_reg[wls_pkg::WC_LOW_LSB +: 2]);
    assign hi_lim = wls_pkg::win_high_cycles(ctrl_reg[wls_pkg::WC_HIGH_LSB +: 2]);
    assign idle_lim = {hi_lim, 1'b0};
    assign good_pulse = fall && measuring_reg && width_reg >= lo_lim && width_reg <= hi_lim;
    assign bad_pulse = fall && measuring_reg && !good_pulse;
    assign timeout = {1'b0, idle_reg} >= idle_lim;

    always_comb begin
        count_next = wd_count_reg;
        if (good_pulse && wd_count_reg != wls_pkg::WD_COUNT_FULL) begin
            count_next = wd_count_reg + 3'h1;
        end else if (bad_pulse) begin
            count_next = (wd_count_reg < wls_pkg::WD_COUNT_BAD_STEP) ? wls_pkg::WD_COUNT_RESET
                : wd_count_reg - wls_pkg::WD_COUNT_BAD_STEP;
        end
    end

    // power-on enters the reset pulse directly
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wd_state_reg <= wls_pkg::WD_RESET_PULSE;
            wd_timer_reg <= wls_pkg::RST_PULSE_CYC;
            rst_drive_reg <= 1'b1;
            wd_count_reg <= wls_pkg::WD_COUNT_RESET;
            watchdog_fault_bit_reg <= 1'b0;
            wd_ok_reg <= 1'b0;
            width_reg <= '0;
            idle_reg <= '0;
            measuring_reg <= 1'b0;
        end else begin
            case (wd_state_reg)
                wls_pkg::WD_RESET_PULSE: begin
                    rst_drive_reg <= 1'b1;
                    wd_ok_reg <= 1'b0;
                    wd_timer_reg <= wd_timer_reg - 14'h0001;
                    if (wd_timer_reg <= 14'h0001) begin
                        wd_state_reg <= wls_pkg::WD_HOLDOFF;
                        wd_timer_reg <= wls_pkg::RESTART_DELAY_CYC;
                        rst_drive_reg <= 1'b0;
                    end
                end
                wls_pkg::WD_HOLDOFF: begin
                    wd_timer_reg <= wd_timer_reg - 14'h0001;
                    wd_count_reg <= wls_pkg::WD_COUNT_RESET;
                    measuring_reg <= 1'b0;
                    idle_reg <= '0;
                    if (wd_timer_reg <= 14'h0001) begin
                        wd_state_reg <= wls_pkg::WD_RUN;
                    end
                end
                wls_pkg::WD_RUN: begin
                    if (!watchdog_enable_bit) begin
                        wd_count_reg <= wls_pkg::WD_COUNT_RESET;
                        watchdog_fault_bit_reg <= 1'b0;
                        wd_ok_reg <= 1'b0;
                        measuring_reg <= 1'b0;
                        idle_reg <= '0;
                    end else begin
                        idle_reg <= (rise || fall) ? 14'h0000 : (timeout ? idle_reg : idle_reg + 14'h0001);
                        if (rise) begin
                            width_reg <= '0;
                            measuring_reg <= 1'b1;
                        end else if (fall) begin
                            measuring_reg <= 1'b0;
                        end else if (measuring_reg && width_reg != '1) begin
                            width_reg <= width_reg + 14'h0001;
                        end
                        wd_count_reg <= count_next;
                        if (count_next == wls_pkg::WD_COUNT_RESET || timeout) begin
                            watchdog_fault_bit_reg <= 1'b1;
                            wd_ok_reg <= 1'b0;
                        end else if (count_next == wls_pkg::WD_COUNT_FULL) begin
                            watchdog_fault_bit_reg <= 1'b0;
                            wd_ok_reg <= 1'b1;
                        end
                        if (bad_pulse && wd_count_reg != wls_pkg::WD_COUNT_RESET
                            && count_next == wls_pkg::WD_COUNT_RESET) begin
                            wd_state_reg <= wls_pkg::WD_RESET_PULSE;
                            wd_timer_reg <= wls_pkg::RST_PULSE_CYC;
                            rst_drive_reg <= 1'b1;
                        end
                    end
                end
                default: begin
                    wd_state_reg <= wls_pkg::WD_RESET_PULSE;
                    wd_timer_reg <= wls_pkg::RST_PULSE_CYC;
                    rst_drive_reg <= 1'b1;
                end
            endcase
        end
    end

    // external reset: ignore our own drive until it has passed the synchroniser
    logic [2:0] drive_hist_reg;
    logic ext_low_reg;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            drive_hist_reg <= '1;
            ext_low_reg <= 1'b0;
        end else begin
            drive_hist_reg <= {drive_hist_reg[1:0], rst_drive_reg};
            if (!rline_s && !rst_drive_reg && drive_hist_reg == 3'h0) begin
                ext_low_reg <= 1'b1;
            end else if (rline_s) begin
                ext_low_reg <= 1'b0;
            end
        end
    end
    assign erst_set = rline_s && ext_low_reg;

    // outputs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= '0;
            low_voltage_lamp_driver_oe_o <= 1'b0;
            lamp_driver_one_o <= 1'b0;
            lamp_driver_two_o <= 1'b0;
            watchdog_ok_flag_o <= 1'b0;
            watchdog_fault_bit_o <= 1'b0;
            function_inhibit_o <= 1'b0;
        end else begin
            low_voltage_lamp_driver_oe_o <= wd_ok_reg;
            lamp_driver_one_o <= lamp_on_reg[0];
            lamp_driver_two_o <= lamp_on_reg[1];
            watchdog_ok_flag_o <= wd_ok_reg;
            watchdog_fault_bit_o <= watchdog_fault_bit_reg;
            function_inhibit_o <= watchdog_enable_bit && watchdog_fault_bit_reg;
            if (rd_sum) begin
                reg_rdata_o <= {5'h00, sum_reg};
            end else if (rd_lamp) begin
                reg_rdata_o <= lamp_fault_reg;
            end else if (rd_wd) begin
                reg_rdata_o <= {3'h0, watchdog_fault_bit_reg, wd_ok_reg, wd_count_reg};
            end else if (reg_req_i.rd && reg_req_i.addr == wls_pkg::ADDR_WD_CONTROL) begin
                reg_rdata_o <= ctrl_reg;
            end else if (reg_req_i.rd) begin
                reg_rdata_o <= 8'h00;
            end
        end
    end
    assign reset_line_oe_o = rst_drive_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_lv_lamp_follow: assert property (low_voltage_lamp_driver_oe_o == $past(wd_ok_reg))
        else $error("low-voltage lamp not following ok flag");
    a_lamp_gate_both: assert property (lamp_on_reg[0] |-> $past(ge[0] && gate_s[0]))
        else $error("lamp one on without gate and enable");
    a_oc_flag_set: assert property (dg_det[0] |=> lamp_fault_reg[wls_pkg::LF_OC_ONE_BIT])
        else $error("overcurrent flag missing");
    a_ot_drivers_off: assert property (dg_det[2] |=> !lamp_on_reg[0] && !lamp_on_reg[1])
        else $error("lamp on during overtemperature");
    a_ol_only_off: assert property ($rose(lamp_fault_reg[wls_pkg::LF_OL_ONE_BIT]) |-> $past(!lamp_on_reg[0]))
        else $error("open load set while driver on");
    a_master_clears: assert property (rd_sum && !(|dg_det[1:0]) && !(|ol_set)
        |=> !sum_reg[wls_pkg::SUM_MASTER_BIT])
        else $error("master fault not cleared by read");
    a_read_keeps_ot: assert property (rd_lamp && dg_det[2] |=> lamp_fault_reg[wls_pkg::LF_OT_BIT])
        else $error("present overtemperature lost on read");
    a_uv_drivers_off: assert property (uv_s |=> !lamp_on_reg[0] && !lamp_on_reg[1])
        else $error("lamp on during undervoltage");
    a_good_increment: assert property (wd_state_reg == wls_pkg::WD_RUN && watchdog_enable_bit && good_pulse
        && wd_count_reg < wls_pkg::WD_COUNT_FULL |=> wd_count_reg == $past(wd_count_reg) + 3'h1)
        else $error("good pulse did not increment");
    a_bad_decrement: assert property (wd_state_reg == wls_pkg::WD_RUN && watchdog_enable_bit && bad_pulse
        && wd_count_reg >= wls_pkg::WD_COUNT_BAD_STEP |=> wd_count_reg == $past(wd_count_reg) - 3'h3)
        else $error("bad pulse did not decrement by three");
    a_zero_fault: assert property (wd_state_reg == wls_pkg::WD_RUN && watchdog_enable_bit && count_next == 3'h0
        |=> watchdog_fault_bit_reg && !wd_ok_reg)
        else $error("zero count without fault");
    a_reset_pulse_hold: assert property ($rose(rst_drive_reg) |-> rst_drive_reg [*8])
        else $error("reset pulse too short");
endmodule : wls_supervisor

`default_nettype wire

// >>> wls_pkg.sv
package wls_pkg;
    localparam int CLK_PERIOD_NS = 8;

    // register offsets
    localparam logic [5:0] ADDR_FAULT_SUMMARY = 6'h00;
    localparam logic [5:0] ADDR_LAMP_FAULT = 6'h03;
    localparam logic [5:0] ADDR_WD_STATUS = 6'h05;
    localparam logic [5:0] ADDR_WD_CONTROL = 6'h11;

    // device_fault_summary fields
    localparam int SUM_MASTER_BIT = 0;
    localparam int SUM_UNDERVOLT_BIT = 1;
    localparam int SUM_EXT_RESET_BIT = 2;
    // lamp_fault_status fields
    localparam int LF_OC_ONE_BIT = 0;
    localparam int LF_OL_ONE_BIT = 1;
    localparam int LF_OC_TWO_BIT = 2;
    localparam int LF_OL_TWO_BIT = 3;
    localparam int LF_OT_BIT = 6;
    // watchdog_count_status fields
    localparam int WS_COUNT_LSB = 0;
    localparam int WS_OK_BIT = 3;
    localparam int WS_FAULT_BIT = 4;
    // watchdog_control fields
    localparam int WC_LOW_LSB = 0;
    localparam int WC_HIGH_LSB = 2;
    localparam int WC_ENABLE_BIT = 4;
    localparam int WC_GE_ONE_BIT = 5;
    localparam int WC_GE_TWO_BIT = 6;
    localparam logic [7:0] WD_CONTROL_RESET = 8'h00;

    localparam logic [2:0] WD_COUNT_FULL = 3'h7;
    localparam logic [2:0] WD_COUNT_BAD_STEP = 3'h3;
    localparam logic [2:0] WD_COUNT_RESET = 3'h0;

    // times in microseconds
    localparam int OC_BLANK_US = 10;
    localparam int OT_DEGLITCH_US = 20;
    localparam int RST_PULSE_US = 10;
    localparam int RESTART_DELAY_US = 30;
    localparam int WIN_LO_US0 = 1;
    localparam int WIN_LO_US1 = 2;
    localparam int WIN_LO_US2 = 3;
    localparam int WIN_LO_US3 = 4;
    localparam int WIN_HI_US0 = 4;
    localparam int WIN_HI_US1 = 8;
    localparam int WIN_HI_US2 = 12;
    localparam int WIN_HI_US3 = 16;

    // least time: round up to whole cycles
    function automatic logic [13:0] us_to_cycles(input int us);
        return 14'((us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : us_to_cycles

    localparam logic [13:0] OC_BLANK_CYC = us_to_cycles(OC_BLANK_US);
    localparam logic [13:0] OT_DEGLITCH_CYC = us_to_cycles(OT_DEGLITCH_US);
    localparam logic [13:0] RST_PULSE_CYC = us_to_cycles(RST_PULSE_US);
    localparam logic [13:0] RESTART_DELAY_CYC = us_to_cycles(RESTART_DELAY_US);

    function automatic logic [13:0] win_low_cycles(input logic [1:0] code);
        case (code)
            2'h0: return us_to_cycles(WIN_LO_US0);
            2'h1: return us_to_cycles(WIN_LO_US1);
            2'h2: return us_to_cycles(WIN_LO_US2);
            default: return us_to_cycles(WIN_LO_US3);
        endcase
    endfunction : win_low_cycles

    function automatic logic [13:0] win_high_cycles(input logic [1:0] code);
        case (code)
            2'h0: return us_to_cycles(WIN_HI_US0);
            2'h1: return us_to_cycles(WIN_HI_US1);
            2'h2: return us_to_cycles(WIN_HI_US2);
            default: return us_to_cycles(WIN_HI_US3);
        endcase
    endfunction : win_high_cycles

    typedef enum logic [1:0] {
        WD_RESET_PULSE = 2'b00,
        WD_HOLDOFF = 2'b01,
        WD_RUN = 2'b10
    } wls_wd_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } wls_reg_req_t;

    typedef struct packed {
        logic undervoltage;
        logic overtemp;
        logic [1:0] open_load;
        logic [1:0] overcurrent;
    } wls_fault_in_t;
endpackage : wls_pkg

// >>> wls_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none

// controller side: strobe pin and a pull on the shared reset wire
module wls_mcu_model (
    input wire logic clk_i,
    output logic strobe_o,
    output logic reset_oe_o
);
    initial begin
        strobe_o = 1'b0;
        reset_oe_o = 1'b0;
    end

    // called at a falling edge; widths in clock cycles
    task automatic pulse(input int high_cyc, input int low_cyc);
        strobe_o = 1'b1;
        repeat (high_cyc) @(negedge clk_i);
        strobe_o = 1'b0;
        repeat (low_cyc) @(negedge clk_i);
    endtask : pulse

    task automatic hold_reset(input int cyc);
        reset_oe_o = 1'b1;
        repeat (cyc) @(negedge clk_i);
        reset_oe_o = 1'b0;
    endtask : hold_reset
endmodule : wls_mcu_model

`default_nettype wire

// >>> watchdog_lamp_supervisor_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module watchdog_lamp_supervisor_tb_top;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    wls_pkg::wls_reg_req_t reg_req_i = '0;
    wls_pkg::wls_fault_in_t fault_in_i = '0;
    logic gate_one = 1'b0;
    logic gate_two = 1'b0;
    logic [7:0] reg_rdata_o;
    logic strobe;
    logic mcu_rst_oe;
    logic reset_line_oe_o;
    logic lv_lamp_oe;
    logic lamp_one;
    logic lamp_two;
    logic ok_flag;
    logic watchdog_fault_bit;
    logic inhibit;
    logic [7:0] rd_val;
    int fail_count = 0;
    int n_checks = 0;
    wire logic reset_wire;

    // open drain with pull-up: low while either party pulls
    assign reset_wire = !(reset_line_oe_o | mcu_rst_oe);

    wls_supervisor i_dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .reg_req_i(reg_req_i),
        .reg_rdata_o(reg_rdata_o),
        .watchdog_strobe_input_i(strobe),
        .lamp_gate_input_one_i(gate_one),
        .lamp_gate_input_two_i(gate_two),
        .fault_in_i(fault_in_i),
        .reset_line_in_i(reset_wire),
        .reset_line_oe_o(reset_line_oe_o),
        .low_voltage_lamp_driver_oe_o(lv_lamp_oe),
        .lamp_driver_one_o(lamp_one),
        .lamp_driver_two_o(lamp_two),
        .watchdog_ok_flag_o(ok_flag),
        .watchdog_fault_bit_o(watchdog_fault_bit),
        .function_inhibit_o(inhibit)
    );

    wls_mcu_model i_mcu (
        .clk_i(clk_i),
        .strobe_o(strobe),
        .reset_oe_o(mcu_rst_oe)
    );

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wait_cyc

    // settle time covers input synchronisers and output registers
    task automatic reg_write(input logic [5:0] addr, input logic [7:0] data);
        reg_req_i = {1'b0, 1'b1, addr, data};
        @(negedge clk_i);
        reg_req_i = '0;
        wait_cyc(8);
    endtask : reg_write

    task automatic reg_read(input logic [5:0] addr);
        reg_req_i = {1'b1, 1'b0, addr, 8'h00};
        @(negedge clk_i);
        reg_req_i = '0;
        rd_val = reg_rdata_o;
        // idle edge keeps back-to-back requests apart
        @(negedge clk_i);
    endtask : reg_read

    task automatic test_reset();
        `CHK(reset_line_oe_o, 1'b1)
        reg_read(wls_pkg::ADDR_WD_CONTROL);
        `CHK(rd_val, wls_pkg::WD_CONTROL_RESET)
        wait_cyc(int'(wls_pkg::RST_PULSE_CYC) + 5);
        `CHK(reset_line_oe_o, 1'b0)
        wait_cyc(int'(wls_pkg::RESTART_DELAY_CYC) + 10);
        i_mcu.hold_reset(20);
        wait_cyc(8);
        reg_read(wls_pkg::ADDR_FAULT_SUMMARY);
        `CHK(rd_val[wls_pkg::SUM_EXT_RESET_BIT], 1'b1)
        reg_read(wls_pkg::ADDR_FAULT_SUMMARY);
        `CHK(rd_val[wls_pkg::SUM_EXT_RESET_BIT], 1'b0)
    endtask : test_reset

    task automatic test_lamps();
        reg_write(wls_pkg::ADDR_WD_CONTROL, 8'h60);
        gate_one = 1'b1;
        wait_cyc(8);
        `CHK(lamp_one, 1'b1)
        `CHK(lamp_two, 1'b0)
        fault_in_i.open_load = 2'b11;
        wait_cyc(int'(wls_pkg::OC_BLANK_CYC) + 10);
        fault_in_i.open_load = 2'b00;
        wait_cyc(8);
        reg_read(wls_pkg::ADDR_LAMP_FAULT);
        `CHK(rd_val[wls_pkg::LF_OL_TWO_BIT], 1'b1)
        // lamp one is on, so no open-load check there
        `CHK(rd_val[wls_pkg::LF_OL_ONE_BIT], 1'b0)
        reg_read(wls_pkg::ADDR_FAULT_SUMMARY);
        `CHK(rd_val[wls_pkg::SUM_MASTER_BIT], 1'b1)
        reg_read(wls_pkg::ADDR_FAULT_SUMMARY);
        `CHK(rd_val[wls_pkg::SUM_MASTER_BIT], 1'b0)
        fault_in_i.overcurrent = 2'b01;
        wait_cyc(int'(wls_pkg::OC_BLANK_CYC) + 10);
        `CHK(lamp_one, 1'b1)
        reg_read(wls_pkg::ADDR_LAMP_FAULT);
        `CHK(rd_val[wls_pkg::LF_OC_ONE_BIT], 1'b1)
        reg_read(wls_pkg::ADDR_LAMP_FAULT);
        `CHK(rd_val[wls_pkg::LF_OC_ONE_BIT], 1'b1)
        fault_in_i.overcurrent = 2'b00;
        wait_cyc(8);
        reg_read(wls_pkg::ADDR_LAMP_FAULT);
        reg_read(wls_pkg::ADDR_LAMP_FAULT);
        `CHK(rd_val[wls_pkg::LF_OC_ONE_BIT], 1'b0)
        reg_read(wls_pkg::ADDR_FAULT_SUMMARY);
        fault_in_i.undervoltage = 1'b1;
        wait_cyc(8);
        `CHK(lamp_one, 1'b0)
        reg_read(wls_pkg::ADDR_FAULT_SUMMARY);
        `CHK(rd_val[wls_pkg::SUM_MASTER_BIT], 1'b0)
        `CHK(rd_val[wls_pkg::SUM_UNDERVOLT_BIT], 1'b1)
        // lamp one is off now, so its open load is seen
        fault_in_i.open_load = 2'b01;
        wait_cyc(8);
        fault_in_i.open_load = 2'b00;
        wait_cyc(8);
        reg_read(wls_pkg::ADDR_LAMP_FAULT);
        `CHK(rd_val[wls_pkg::LF_OL_ONE_BIT], 1'b1)
        reg_read(wls_pkg::ADDR_FAULT_SUMMARY);
        fault_in_i.undervoltage = 1'b0;
        wait_cyc(8);
        // undervoltage flag is still stored here, yet the lamp returns
        `CHK(lamp_one, 1'b1)
        fault_in_i.overtemp = 1'b1;
        wait_cyc(8);
        `CHK(lamp_one, 1'b1)
        wait_cyc(int'(wls_pkg::OT_DEGLITCH_CYC));
        `CHK(lamp_one, 1'b0)
        reg_read(wls_pkg::ADDR_LAMP_FAULT);
        `CHK(rd_val[wls_pkg::LF_OT_BIT], 1'b1)
        fault_in_i.overtemp = 1'b0;
        wait_cyc(int'(wls_pkg::OT_DEGLITCH_CYC) + 10);
    endtask : test_lamps

    task automatic test_watchdog();
        reg_write(wls_pkg::ADDR_WD_CONTROL, 8'h70);
        `CHK(watchdog_fault_bit, 1'b1)
        `CHK(inhibit, 1'b1)
        `CHK(lamp_one, 1'b0)
        repeat (3) i_mcu.pulse(200, 100);
        reg_read(wls_pkg::ADDR_WD_STATUS);
        `CHK(rd_val[2:0], 3'h3)
        i_mcu.pulse(50, 10);
        `CHK(reset_line_oe_o, 1'b1)
        `CHK(ok_flag, 1'b0)
        wait_cyc(int'(wls_pkg::RST_PULSE_CYC));
        `CHK(reset_line_oe_o, 1'b0)
        wait_cyc(int'(wls_pkg::RESTART_DELAY_CYC) + 10);
        repeat (7) i_mcu.pulse(200, 100);
        reg_read(wls_pkg::ADDR_WD_STATUS);
        `CHK(rd_val[4:0], 5'h0f)
        `CHK(lv_lamp_oe, 1'b1)
        `CHK(lamp_one, 1'b1)
        `CHK(inhibit, 1'b0)
        i_mcu.pulse(50, 10);
        reg_read(wls_pkg::ADDR_WD_STATUS);
        `CHK(rd_val[2:0], 3'h4)
        // strobe idles past twice the upper window of code 0
        wait_cyc(1100);
        `CHK(watchdog_fault_bit, 1'b1)
        `CHK(ok_flag, 1'b0)
        `CHK(lv_lamp_oe, 1'b0)
        // lower code 3: a width good under code 0 is now too short
        reg_write(wls_pkg::ADDR_WD_CONTROL, 8'h7f);
        i_mcu.pulse(200, 100);
        reg_read(wls_pkg::ADDR_WD_STATUS);
        `CHK(rd_val[4:0], 5'h11)
    endtask : test_watchdog

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    initial begin
        // about twice the expected length of all scenarios
        #(40000 * wls_pkg::CLK_PERIOD_NS);
        fail_count++;
        stop_test();
    end

    initial begin
        wait_cyc(20);
        reset_i = 1'b0;
        @(negedge clk_i);
        test_reset();
        test_lamps();
        test_watchdog();
        stop_test();
    end
endmodule : watchdog_lamp_supervisor_tb_top

`default_nettype wire
